// file: include/adcc_pkg.sv
// Types and helpers shared by the converter control block
`include "adcc_regs.svh"

package adcc_pkg;

    typedef struct packed {
        logic        enable;
        logic        freerun;
        logic        ev_start;
        logic [1:0]  ressel;
        logic [2:0]  samplenum;
        logic        leftadj;
        logic        diffmode;
        logic        multi_ch;
        logic [4:0]  muxpos;
        logic [4:0]  muxneg;
        logic [2:0]  winmode;
        logic [4:0]  winchan;
        logic [15:0] win_lo;
        logic [15:0] win_hi;
    } adcc_cfg_t;

    typedef struct packed {
        logic [4:0] muxpos;
        logic [4:0] muxneg;
    } adcc_dmacfg_t;

    typedef struct packed {
        logic result_ready_flag;
        logic overrun;
        logic winmon;
    } adcc_flags_t;

    typedef enum logic [3:0] {
        ADCC_IDLE    = 4'b0001,
        ADCC_CONV    = 4'b0010,
        ADCC_RELEASE = 4'b0100,
        ADCC_DONE    = 4'b1000
    } adcc_state_t;

    // Oversampling count, capped at the 16-bit ceiling
    function automatic logic [2:0] adcc_sn(input logic [2:0] sn);
        adcc_sn = (sn > `ADCC_MAX_SAMPLENUM) ? `ADCC_MAX_SAMPLENUM : sn;
    endfunction

    // Result width in bits for a resolution setting
    function automatic logic [4:0] adcc_res_bits(input logic [1:0] ressel,
                                                 input logic [2:0] sn);
        unique case (ressel)
            `ADCC_RES_8:   adcc_res_bits = `ADCC_BITS_8;
            `ADCC_RES_10:  adcc_res_bits = `ADCC_BITS_10;
            `ADCC_RES_OVS: adcc_res_bits = `ADCC_BITS_12 + {2'h0, adcc_sn(sn)};
            default:       adcc_res_bits = `ADCC_BITS_12;
        endcase
    endfunction

endpackage

// file: include/adcc_regs.svh
// Constants of the converter control block
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_CORE_BITS      12
`define ADCC_RESULT_BITS    16
`define ADCC_RES_12         2'h0
`define ADCC_RES_OVS        2'h1
`define ADCC_RES_10         2'h2
`define ADCC_RES_8          2'h3
`define ADCC_BITS_8         5'h08
`define ADCC_BITS_10        5'h0A
`define ADCC_BITS_12        5'h0C
`define ADCC_BITS_FULL      5'h10
`define ADCC_MAX_SAMPLENUM  3'h4
`define ADCC_ONE_SAMPLE     5'h01
`define ADCC_WIN_OFF        3'h0
`define ADCC_WIN_ABOVE      3'h1
`define ADCC_WIN_BELOW      3'h2
`define ADCC_WIN_INSIDE     3'h3
`define ADCC_WIN_OUTSIDE    3'h4
`define ADCC_SYNC_CYC       2'h3
`define ADCC_SYNC_LAST      2'h1

`endif

// file: src/adcc_fmt.sv
// Result adjustment: sign extension and left or right alignment
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"

module adcc_fmt (
    input  wire logic [15:0] val_i,
    input  wire logic [4:0]  nbits_i,
    input  wire logic        leftadj_i,
    input  wire logic        sgn_i,
    output logic      [15:0] res_o
);
    logic [15:0] mask;
    logic [15:0] right;
    logic        sbit;

    always_comb begin
        mask  = 16'hFFFF << nbits_i;
        sbit  = val_i[4'(nbits_i - 5'h01)];
        // Signed results sign-extend, unsigned ones clear the upper bits
        right = (sgn_i && sbit) ? (val_i | mask) : (val_i & ~mask); // RQ5
        res_o = leftadj_i ? (val_i << (`ADCC_BITS_FULL - nbits_i))
                          : right; // RQ4
    end
endmodule // adcc_fmt

`default_nettype wire

// file: src/adcc_sync.sv
// Two-stage synchroniser for signals from the analog core
`timescale 1ns/100ps
`default_nettype none

module adcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // adcc_sync

`default_nettype wire

// file: src/adcc_top.sv
// Converter digital control: triggers, accumulation, results, flags
// What this block does
// RQ1 - Results are 12 bits by default; 8 or 10 bits selectable.
// RQ2 - Conversion starts from a software trigger or a peripheral event.
// RQ3 - Exactly one event input triggers conversions.
// RQ4 - Results are left- or right-adjusted as configured.
// RQ5 - Results can be signed or unsigned.
// RQ6 - Input is single-ended or differential, from any selectable source.
// RQ7 - Oversampling with decimation extends results up to 16 bits.
// RQ8 - Window compare checks results against thresholds on one channel.
// RQ9 - Each completed conversion raises a DMA request.
// RQ10 - DMA can write conversion input settings into the block.
// RQ11 - Operation continues in sleep while the source clock runs.
// RQ12 - Flags drive a wake request; output events need no wake-up.
// RQ13 - Configuration writes pass a synchronisation delay before use.
// RQ14 - Debug halt stops operation unless debug-run is set.
// RQ15 - Configuration writes obey write protection; flag clears do not.
// RQ16 - Debugger accesses bypass write protection.
// RQ17 - Software enables the conversion clock before use.
// RQ18 - Software loads factory calibration values before use.
// RQ19 - Each new result replaces the previous one.
// RQ20 - Unread result with several channels enabled sets overrun.
// RQ21 - Result-ready pulses exactly once per completed conversion.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"

module adcc_top
    import adcc_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  cfg_wr_i,
    input  wire adcc_cfg_t             cfg_i,
    input  wire logic                  dma_cfg_valid_i,
    input  wire adcc_dmacfg_t          dma_cfg_i,
    input  wire logic                  wprot_i,
    input  wire logic                  dbg_access_i,
    input  wire logic                  cpu_halt_i,
    input  wire logic                  dbg_run_i,
    input  wire logic                  clk_run_i,
    input  wire logic                  sw_start_i,
    input  wire logic                  event_i,
    input  wire logic                  result_rd_i,
    input  wire adcc_flags_t           flag_clr_i,
    input  wire logic                  core_done_i,
    input  wire logic [11:0]           core_data_i,
    output logic                       core_start_o,
    output logic [1:0]                 core_ressel_o,
    output logic                       core_diff_o,
    output logic [4:0]                 core_muxpos_o,
    output logic [4:0]                 core_muxneg_o,
    output logic [15:0]                result_o,
    output adcc_flags_t                flags_o,
    output logic                       irq_o,
    output logic                       dma_req_o,
    output logic                       dma_cfg_ack_o,
    output logic                       result_ready_flag_ev_o,
    output logic                       win_ev_o,
    output logic                       sync_busy_o,
    output logic                       busy_o
);
    // Configuration shadow and synchronised active copy
    adcc_cfg_t   shadow_q, shadow_d, cfg_q, cfg_d;
    logic        pend_q, pend_d, dack_q, dack_d;
    logic [1:0]  scnt_q, scnt_d;
    logic        wr_ok, dma_ok;

    assign wr_ok  = cfg_wr_i && (!wprot_i || dbg_access_i); // RQ15 RQ16
    assign dma_ok = dma_cfg_valid_i && (!wprot_i || dbg_access_i); // RQ15

    always_comb begin
        shadow_d = shadow_q;
        cfg_d    = cfg_q;
        pend_d   = pend_q;
        scnt_d   = scnt_q;
        dack_d   = 1'b0;
        if (wr_ok) begin
            shadow_d = cfg_i;
            pend_d   = 1'b1;
            scnt_d   = `ADCC_SYNC_CYC; // RQ13
        end else if (dma_ok) begin
            shadow_d.muxpos = dma_cfg_i.muxpos; // RQ10
            shadow_d.muxneg = dma_cfg_i.muxneg; // RQ10
            pend_d          = 1'b1;
            scnt_d          = `ADCC_SYNC_CYC;
            dack_d          = 1'b1;
        end else if (pend_q) begin
            scnt_d = scnt_q - 2'h1;
            if (scnt_q == `ADCC_SYNC_LAST) begin
                cfg_d  = shadow_q; // RQ13
                pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shadow_q <= '0;
            cfg_q    <= '0;
            pend_q   <= 1'b0;
            scnt_q   <= 2'h0;
            dack_q   <= 1'b0;
        end else begin
            shadow_q <= shadow_d;
            cfg_q    <= cfg_d;
            pend_q   <= pend_d;
            scnt_q   <= scnt_d;
            dack_q   <= dack_d;
        end
    end

    // Analog core handshake inputs cross into the control clock
    logic [12:0] core_s;
    logic        done_s, done_s_q;
    logic [11:0] data_s;

    adcc_sync #(.WIDTH(13)) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   ({core_done_i, core_data_i}),
        .sync_o    (core_s)
    );
    assign done_s = core_s[12];
    assign data_s = core_s[11:0];

    // Conversion sequencer
    adcc_state_t state_q, state_d;
    logic        start_q, start_d, trig_q, trig_d;
    logic [15:0] acc_q, acc_d;
    logic [4:0]  nsamp_q, nsamp_d, target;
    logic        run, done_rise;

    // Halts in debug unless told to run; also stops when disabled or without source clock
    assign run = cfg_q.enable && clk_run_i
              && (!cpu_halt_i || dbg_run_i); // RQ11 RQ14
    assign done_rise = done_s && !done_s_q;
    assign target = (cfg_q.ressel == `ADCC_RES_OVS)
                  ? (`ADCC_ONE_SAMPLE << adcc_sn(cfg_q.samplenum)) // RQ7
                  : `ADCC_ONE_SAMPLE;

    always_comb begin
        state_d = state_q;
        start_d = start_q;
        acc_d   = acc_q;
        nsamp_d = nsamp_q;
        trig_d  = trig_q || sw_start_i
               || (cfg_q.ev_start && event_i); // RQ2 RQ3
        unique case (state_q)
            ADCC_IDLE: begin
                if (run && trig_q) begin
                    state_d = ADCC_CONV;
                    start_d = 1'b1;
                    trig_d  = 1'b0;
                    acc_d   = '0;
                    nsamp_d = '0;
                end
            end
            ADCC_CONV: begin
                if (done_rise) begin
                    start_d = 1'b0;
                    nsamp_d = nsamp_q + 5'h01;
                    // Differential samples accumulate sign-extended
                    acc_d   = acc_q + {{4{data_s[11] && cfg_q.diffmode}},
                                       data_s}; // RQ6 RQ7
                    state_d = ADCC_RELEASE;
                end
            end
            ADCC_RELEASE: begin
                if (!done_s && run) begin
                    if (nsamp_q == target) begin
                        state_d = ADCC_DONE;
                    end else begin
                        state_d = ADCC_CONV;
                        start_d = 1'b1;
                    end
                end
            end
            ADCC_DONE: begin
                state_d = ADCC_IDLE;
                if (cfg_q.freerun) begin
                    trig_d = 1'b1;
                end
            end
            default: begin
                state_d = ADCC_IDLE;
                start_d = 1'b0;
            end
        endcase
        if (!cfg_q.enable) begin
            trig_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q  <= ADCC_IDLE;
            start_q  <= 1'b0;
            trig_q   <= 1'b0;
            acc_q    <= '0;
            nsamp_q  <= '0;
            done_s_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            start_q  <= start_d;
            trig_q   <= trig_d;
            acc_q    <= acc_d;
            nsamp_q  <= nsamp_d;
            done_s_q <= done_s;
        end
    end

    // Result formatting, window compare and flags
    logic [4:0]  nbits;
    logic [15:0] fmt_res;
    logic        done_evt, hit, lo_ok, hi_ok;
    logic [15:0] result_q, result_d;
    adcc_flags_t flags_q, flags_d;
    logic        irq_q, irq_d, dreq_q, dreq_d;
    logic        wev_q, wev_d, busy_q, busy_d;

    assign nbits    = adcc_res_bits(cfg_q.ressel, cfg_q.samplenum); // RQ1
    assign done_evt = (state_q == ADCC_DONE);

    adcc_fmt u_fmt (
        .val_i     (acc_q),
        .nbits_i   (nbits),
        .leftadj_i (cfg_q.leftadj),
        .sgn_i     (cfg_q.diffmode),
        .res_o     (fmt_res)
    );

    always_comb begin
        lo_ok = cfg_q.diffmode ? ($signed(acc_q) > $signed(cfg_q.win_lo))
                               : (acc_q > cfg_q.win_lo);
        hi_ok = cfg_q.diffmode ? ($signed(acc_q) < $signed(cfg_q.win_hi))
                               : (acc_q < cfg_q.win_hi);
        unique case (cfg_q.winmode)
            `ADCC_WIN_ABOVE:   hit = lo_ok;
            `ADCC_WIN_BELOW:   hit = hi_ok;
            `ADCC_WIN_INSIDE:  hit = lo_ok && hi_ok;
            `ADCC_WIN_OUTSIDE: hit = !(lo_ok && hi_ok);
            default:           hit = 1'b0;
        endcase
        hit = hit && (cfg_q.muxpos == cfg_q.winchan); // RQ8

        result_d = done_evt ? fmt_res : result_q; // RQ19
        // A setting event wins over a clear in the same cycle
        flags_d.result_ready_flag  = done_evt || (flags_q.result_ready_flag
                       && !(flag_clr_i.result_ready_flag || result_rd_i)); // RQ21
        flags_d.overrun = (done_evt && flags_q.result_ready_flag && cfg_q.multi_ch)
                       || (flags_q.overrun && !flag_clr_i.overrun); // RQ20
        flags_d.winmon  = (done_evt && hit)
                       || (flags_q.winmon && !flag_clr_i.winmon); // RQ8
        irq_d  = |flags_d; // RQ12
        dreq_d = done_evt; // RQ9 RQ21
        wev_d  = done_evt && hit; // RQ12
        busy_d = (state_d != ADCC_IDLE);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_q <= '0;
            flags_q  <= '0;
            irq_q    <= 1'b0;
            dreq_q   <= 1'b0;
            wev_q    <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            result_q <= result_d;
            flags_q  <= flags_d;
            irq_q    <= irq_d;
            dreq_q   <= dreq_d;
            wev_q    <= wev_d;
            busy_q   <= busy_d;
        end
    end

    assign core_start_o  = start_q;
    assign core_ressel_o = cfg_q.ressel;
    assign core_diff_o   = cfg_q.diffmode;
    assign core_muxpos_o = cfg_q.muxpos;
    assign core_muxneg_o = cfg_q.muxneg;
    assign result_o      = result_q;
    assign flags_o       = flags_q;
    assign irq_o         = irq_q;
    assign dma_req_o     = dreq_q;
    assign dma_cfg_ack_o = dack_q;
    assign result_ready_flag_ev_o   = dreq_q;
    assign win_ev_o      = wev_q;
    assign sync_busy_o   = pend_q;
    assign busy_o        = busy_q;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    res_default_a: assert property (cfg_q.ressel == `ADCC_RES_12 // RQ1
        |-> nbits == `ADCC_BITS_12)
        else $error("default resolution is not 12 bits");
    event_start_a: assert property (state_q == ADCC_IDLE && run // RQ2
        && !trig_q && cfg_q.ev_start && event_i |=> trig_q ##1 start_q)
        else $error("event did not start a conversion");
    left_adj_a: assert property (done_evt && cfg_q.leftadj // RQ4
        && nbits == `ADCC_BITS_12 |=> result_o[3:0] == 4'h0)
        else $error("left adjusted result has low bits set");
    sign_ext_a: assert property (done_evt && !cfg_q.leftadj // RQ5
        && cfg_q.diffmode && nbits == `ADCC_BITS_12
        |=> result_o[15:12] == {4{result_o[11]}})
        else $error("signed result not sign extended");
    sync_delay_a: assert property (wr_ok ##1 (!wr_ok && !dma_ok) [*3] // RQ13
        |=> cfg_q == $past(shadow_q))
        else $error("configuration not applied after sync delay");
    protect_a: assert property (cfg_wr_i && wprot_i && !dbg_access_i // RQ15
        && !dma_ok |=> shadow_q == $past(shadow_q))
        else $error("protected write changed configuration");
    debug_halt_a: assert property (state_q == ADCC_IDLE && cpu_halt_i // RQ14
        && !dbg_run_i |=> state_q == ADCC_IDLE)
        else $error("conversion started while halted in debug");
    overrun_set_a: assert property (done_evt && flags_q.result_ready_flag // RQ20
        && cfg_q.multi_ch |=> flags_o.overrun)
        else $error("overrun not flagged");
    ready_once_a: assert property (dma_req_o |=> !dma_req_o ##0 // RQ21 RQ9
        $past(state_q, 2) == ADCC_DONE)
        else $error("result ready not single pulse per conversion");
    new_result_a: assert property (done_evt // RQ19
        |=> result_o == $past(fmt_res))
        else $error("result not replaced");

    conv_done_c: cover property (done_evt ##1 dma_req_o);
    ovs_c: cover property (done_evt && target == 5'h10);
    win_c: cover property (win_ev_o);
    overrun_c: cover property ($rose(flags_o.overrun));
endmodule // adcc_top

`default_nettype wire

// file: verif/adcc_core_model.sv
// Behavioural analog core answering the start/done handshake
`timescale 1ns/100ps
`default_nettype none

module adcc_core_model (
    input  wire logic        ref_clk_i,
    input  wire logic        start_i,
    input  wire logic [11:0] sample_i,
    input  wire logic [3:0]  delay_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    initial begin
        done_o = 1'b0;
        data_o = 12'h5A5;
        forever begin
            wait (start_i === 1'b1);
            repeat (delay_i) @(posedge ref_clk_i);
            // Samples stand for a core with calibration already loaded
            #1 data_o = sample_i;
            #1 done_o = 1'b1;
            wait (start_i === 1'b0);
            repeat (delay_i) @(posedge ref_clk_i);
            #1 done_o = 1'b0;
            // Data no longer valid once done drops
            #1 data_o = ~sample_i;
        end
    end
endmodule // adcc_core_model

`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import adcc_pkg::*;

    logic         ref_clk_i = 1'b0;
    logic         arst_n_i = 1'b0;
    logic         cfg_wr_i = 1'b0;
    adcc_cfg_t    cfg = '0;
    logic         dma_v = 1'b0;
    adcc_dmacfg_t dma_cfg = '0;
    logic         wprot_i = 1'b0;
    logic         dbg_acc = 1'b0;
    logic         cpu_halt_i = 1'b0;
    logic         dbg_run_i = 1'b0;
    logic         clk_run_i = 1'b1;
    logic         sw_start_i = 1'b0;
    logic         event_i = 1'b0;
    logic         rd_i = 1'b0;
    adcc_flags_t  flag_clr = '0;
    logic [11:0]  sample = 12'h0;
    logic [3:0]   delay = 4'h1;
    logic         done;
    logic [11:0]  data;
    logic         start, irq_o, dma_req_o, ack, rev, win_ev, sbusy, busy_o;
    logic [1:0]   ressel;
    logic         diff;
    logic [4:0]   mpos, mneg;
    logic [15:0]  result_o;
    adcc_flags_t  flags_o;
    int           n_fail = 0;
    int           check_count = 0;
    int           n_req = 0;
    int           n_win = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    adcc_top adcc_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .cfg_wr_i(cfg_wr_i), .cfg_i(cfg), .dma_cfg_valid_i(dma_v),
        .dma_cfg_i(dma_cfg), .wprot_i(wprot_i), .dbg_access_i(dbg_acc),
        .cpu_halt_i(cpu_halt_i), .dbg_run_i(dbg_run_i),
        .clk_run_i(clk_run_i), .sw_start_i(sw_start_i), .event_i(event_i),
        .result_rd_i(rd_i), .flag_clr_i(flag_clr), .core_done_i(done),
        .core_data_i(data), .core_start_o(start), .core_ressel_o(ressel),
        .core_diff_o(diff), .core_muxpos_o(mpos), .core_muxneg_o(mneg),
        .result_o(result_o), .flags_o(flags_o), .irq_o(irq_o),
        .dma_req_o(dma_req_o), .dma_cfg_ack_o(ack), .result_ready_flag_ev_o(rev),
        .win_ev_o(win_ev), .sync_busy_o(sbusy), .busy_o(busy_o));

    adcc_core_model adcc_core_model_i (.ref_clk_i(ref_clk_i),
        .start_i(start), .sample_i(sample), .delay_i(delay),
        .done_o(done), .data_o(data));

    always @(posedge ref_clk_i) begin
        if (dma_req_o === 1'b1) n_req++;
        if (win_ev === 1'b1) n_win++;
    end

    task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    function automatic adcc_cfg_t mk(input logic [3:0] ctl,
                                     input logic [2:0] sn);
        adcc_cfg_t c;
        c = '0;
        c.enable = 1'b1;
        {c.ressel, c.leftadj, c.diffmode} = ctl;
        c.samplenum = sn;
        c.muxpos = 5'h03;
        c.muxneg = 5'h01;
        c.winchan = 5'h03;
        c.win_lo = 16'h0100;
        c.win_hi = 16'h0300;
        return c;
    endfunction

    task automatic wcfg(input adcc_cfg_t c);
        @(posedge ref_clk_i);
        cfg <= c;
        cfg_wr_i <= 1'b1;
        @(posedge ref_clk_i) cfg_wr_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask

    task automatic pulse(input logic [1:0] src);
        @(posedge ref_clk_i);
        sw_start_i <= (src == 2'h0);
        event_i <= (src == 2'h1);
        rd_i <= (src == 2'h3);
        @(posedge ref_clk_i);
        {sw_start_i, event_i, rd_i} <= 3'h0;
    endtask

    task automatic clr;
        @(posedge ref_clk_i) flag_clr <= '1;
        @(posedge ref_clk_i) flag_clr <= '0;
        pulse(2'h3);
    endtask

    // Source 0 software, 1 event, 2 already pending
    task automatic run(input logic [15:0] exp, input logic [1:0] src);
        int k, n0;
        n0 = n_req;
        k = 0;
        if (src != 2'h2) pulse(src);
        do begin
            @(negedge ref_clk_i);
            k++;
        end while (dma_req_o !== 1'b1 && k < 1000);
        cmp(exp, result_o);
        cmp(16'h1, 16'(rev));
        cmp(16'h1, 16'(irq_o));
        repeat (6) @(negedge ref_clk_i);
        cmp(16'h1, 16'(n_req - n0));
        cmp(16'h1, 16'(flags_o.result_ready_flag));
    endtask

    task automatic idle_chk(input logic [1:0] src);
        int n0;
        n0 = n_req;
        pulse(src);
        repeat (30) @(negedge ref_clk_i);
        cmp(16'(n0), 16'(n_req));
        cmp(16'h0, 16'(busy_o));
    endtask

    task automatic t_format;
        logic [39:0] tb [11];
        tb = '{40'h0009C309C3, 40'h2009C39C30, 40'hA002C5B140,
               40'h8002C502C5, 40'hC000B700B7, 40'hE000B7B700,
               40'h100F00FF00, 40'h300F00F000, 40'h1001230123,
               40'h440FFFFFF0, 40'h4200800200};
        for (int i = 0; i < 11; i++) begin
            wcfg(mk(tb[i][39:36], tb[i][34:32]));
            @(posedge ref_clk_i) sample <= tb[i][27:16];
            delay <= i[0] ? 4'h9 : 4'h1;
            run(tb[i][15:0], 2'h0);
            cmp(16'(tb[i][39:38]), 16'(ressel));
            cmp(16'(tb[i][36]), 16'(diff));
            pulse(2'h3);
        end
        $display("test format done");
    endtask

    task automatic t_window;
        adcc_cfg_t c;
        logic hit;
        int n0;
        for (int m = 0; m < 11; m++) begin
            c = mk(4'h0, 3'h0);
            c.winmode = (m == 10) ? 3'h1 : 3'(m / 2);
            if (m == 10) c.winchan = 5'h04;
            hit = (m == 10) ? 1'b0 : 1'((m[0] ? 5'h14 : 5'h0E) >> (m / 2));
            wcfg(c);
            clr;
            @(posedge ref_clk_i) sample <= m[0] ? 12'h050 : 12'h200;
            n0 = n_win;
            run(m[0] ? 16'h0050 : 16'h0200, 2'h0);
            cmp(16'(hit), 16'(flags_o.winmon));
            cmp(16'(hit), 16'(n_win - n0));
        end
        $display("test window done");
    endtask

    task automatic t_overrun;
        adcc_cfg_t c;
        for (int m = 0; m < 2; m++) begin
            c = mk(4'h0, 3'h0);
            c.multi_ch = m[0];
            wcfg(c);
            clr;
            @(posedge ref_clk_i) sample <= 12'h111;
            run(16'h0111, 2'h0);
            @(posedge ref_clk_i) sample <= 12'h222;
            run(16'h0222, 2'h0);
            cmp(16'(m), 16'(flags_o.overrun));
        end
        clr;
        $display("test overrun done");
    endtask

    task automatic t_trigger;
        adcc_cfg_t c;
        c = mk(4'h0, 3'h0);
        wcfg(c);
        @(posedge ref_clk_i) sample <= 12'h4D2;
        idle_chk(2'h1);
        c.ev_start = 1'b1;
        wcfg(c);
        run(16'h04D2, 2'h1);
        @(posedge ref_clk_i) cpu_halt_i <= 1'b1;
        idle_chk(2'h0);
        @(posedge ref_clk_i) cpu_halt_i <= 1'b0;
        run(16'h04D2, 2'h2);
        @(posedge ref_clk_i) {dbg_run_i, cpu_halt_i} <= 2'h3;
        run(16'h04D2, 2'h0);
        @(posedge ref_clk_i) {cpu_halt_i, clk_run_i} <= 2'h0;
        idle_chk(2'h0);
        @(posedge ref_clk_i) clk_run_i <= 1'b1;
        run(16'h04D2, 2'h2);
        c.freerun = 1'b1;
        wcfg(c);
        run(16'h04D2, 2'h0);
        run(16'h04D2, 2'h2);
        $display("test trigger done");
    endtask

    task automatic dcfg(input logic [9:0] d, input logic ok);
        @(posedge ref_clk_i);
        dma_cfg <= d;
        dma_v <= 1'b1;
        @(posedge ref_clk_i) dma_v <= 1'b0;
        @(negedge ref_clk_i);
        cmp(16'(ok), 16'(ack));
        repeat (6) @(negedge ref_clk_i);
    endtask

    task automatic t_protect;
        adcc_cfg_t c;
        c = mk(4'h0, 3'h0);
        wcfg(c);
        c.muxpos = 5'h0B;
        @(posedge ref_clk_i);
        cfg <= c;
        cfg_wr_i <= 1'b1;
        @(posedge ref_clk_i) cfg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        cmp(16'h1, 16'(sbusy));
        cmp(16'h03, 16'(mpos));
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        cmp(16'h0B, 16'(mpos));
        cmp(16'h0, 16'(sbusy));
        @(posedge ref_clk_i) wprot_i <= 1'b1;
        c.muxpos = 5'h0E;
        wcfg(c);
        cmp(16'h0B, 16'(mpos));
        dcfg(10'h0E2, 1'b0);
        cmp(16'h0B, 16'(mpos));
        @(posedge ref_clk_i) dbg_acc <= 1'b1;
        wcfg(c);
        cmp(16'h0E, 16'(mpos));
        @(posedge ref_clk_i) dbg_acc <= 1'b0;
        run(16'h04D2, 2'h0);
        clr;
        @(negedge ref_clk_i);
        cmp(16'h0, 16'({flags_o, irq_o}));
        @(posedge ref_clk_i) wprot_i <= 1'b0;
        dcfg({5'h07, 5'h02}, 1'b1);
        cmp(16'h0E2, 16'({mpos, mneg}));
        $display("test protect done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(negedge ref_clk_i);
        cmp(16'h0, {result_o[15:2], busy_o, start});
        t_format;
        t_window;
        t_overrun;
        t_trigger;
        t_protect;
        summarize;
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        n_fail++;
        summarize;
    end
endmodule // testbench

`default_nettype wire
